// *** test/awb_ae_window_stats_ctrl_tb.sv ***
// Self-checking bench for the statistics and gain controller over APB and a modelled sensor.
// Assumes the register header on the include path and the sensor model's fixed frame geometry.
`timescale 1ns/1ns
`default_nettype none
`include "awb_ae_consts.vh"
module awb_ae_window_stats_ctrl_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, gainUpdate, wbLocked, go = 1'b0, busy;
	logic        frameStart, lineStart, frameEnd, pixelValid;
	logic [7:0]  pixY, pixCb, pixCr, lumaIn = 8'h80, cbIn = 8'h80, crIn = 8'h80, cbOut = 8'h80, crOut = 8'h80;
	logic [5:0]  redGain, greenGain, blueGain, sensorRed, sensorGreen, sensorBlue;
	int          mismatches = 0;
	int          checks = 0;
	logic [7:0]  regIdx [10] = '{`IDX_CORNER_W, `IDX_SIDE_W, `IDX_CENTER_W, `IDX_CORNER_H, `IDX_SIDE_H,
		`IDX_CENTER_H, `IDX_GAIN_UPPER, `IDX_GAIN_LOWER, `IDX_WB_FILTER, `IDX_WB_LOCK};
	logic [7:0]  regRst [10] = '{`RST_CORNER_W, `RST_SIDE_W, `RST_CENTER_W, `RST_CORNER_H, `RST_SIDE_H,
		`RST_CENTER_H, `RST_GAIN_UPPER, `RST_GAIN_LOWER, `RST_WB_FILTER, `RST_WB_LOCK};
	// Sizes are actual pixel counts since the frame is taken as full-size display
	logic [7:0]  regCfg [10] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h01, 8'h01, 8'h22, 8'h1e, 8'hfc, 8'hb8};

	always #10 clk = ~clk;

	awb_ae_window_stats_ctrl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frameStart(frameStart), .lineStart(lineStart), .frameEnd(frameEnd), .pixelValid(pixelValid),
		.pixY(pixY), .pixCb(pixCb), .pixCr(pixCr), .redGain(redGain), .greenGain(greenGain),
		.blueGain(blueGain), .gainUpdate(gainUpdate), .wbLocked(wbLocked));
	image_sensor_model sensor (.clk(clk), .rst_n(rst_n), .go(go), .lumaIn(lumaIn), .cbIn(cbIn), .crIn(crIn),
		.cbOut(cbOut), .crOut(crOut), .busy(busy), .frameStart(frameStart), .lineStart(lineStart),
		.frameEnd(frameEnd), .pixelValid(pixelValid), .pixY(pixY), .pixCb(pixCb), .pixCr(pixCr),
		.gainUpdate(gainUpdate), .redGain(redGain), .greenGain(greenGain), .blueGain(blueGain),
		.sensorRed(sensorRed), .sensorGreen(sensorGreen), .sensorBlue(sensorBlue));

	task automatic conclude();
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s: got %h, want %h", $time, what, seen, exp);
		end
	endtask

	task automatic timedOut();
		mismatches++;
		$display("[ERR] %0t wait ran out", $time);
		conclude();
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			timedOut();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(1'b1, idx, {24'h0, d}, rd, err);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, idx, 32'h0, rd, err);
		check(rd, {24'h0, exp}, "register read");
	endtask

	task automatic frame(input logic [7:0] y, cbI, crI, cbO, crO, input logic [5:0] eRed, eBlue,
		input logic eLock);
		int n;
		{lumaIn, cbIn, crIn, cbOut, crOut} <= {y, cbI, crI, cbO, crO};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b0 && n < 100);
		if (n >= 100)
			timedOut();
		check({26'h0, sensorRed}, {26'h0, eRed}, "red gain");
		check({26'h0, sensorBlue}, {26'h0, eBlue}, "blue gain");
		check({26'h0, sensorGreen}, 32'h20, "green gain");
		check({31'h0, wbLocked}, {31'h0, eLock}, "lock state");
	endtask

	task automatic regTest();
		logic [31:0] rd;
		logic err;
		for (int i = 0; i < 10; i++)
			rdc(regIdx[i], regRst[i]);
		for (int i = 0; i < 10; i++)
		begin
			wr(regIdx[i], 8'ha5 ^ regIdx[i]);
			rdc(regIdx[i], 8'ha5 ^ regIdx[i]);
		end
		apb(1'b1, 8'h10, 32'hff, rd, err);
		check({31'h0, err}, 32'h1, "unmapped write");
		apb(1'b0, 8'h10, 32'h0, rd, err);
		check({err, rd[30:0]}, 32'h80000000, "unmapped read");
		wr(`IDX_STAT_SEL, 8'h0c);
		rdc(`IDX_STAT_SEL, 8'h08);
		for (int i = 0; i < 10; i++)
			wr(regIdx[i], regCfg[i]);
	endtask

	task automatic stepClamp();
		frame(8'h80, 8'h60, 8'ha0, 8'h60, 8'ha0, 6'h1f, 6'h21, 1'b0);
		frame(8'h80, 8'h60, 8'ha0, 8'h60, 8'ha0, 6'h1e, 6'h22, 1'b0);
		frame(8'h80, 8'h60, 8'ha0, 8'h60, 8'ha0, 6'h1e, 6'h22, 1'b0);
	endtask

	task automatic lockHyst();
		frame(8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 6'h1e, 6'h22, 1'b1);
		frame(8'h80, 8'h80, 8'h85, 8'h80, 8'h85, 6'h1e, 6'h22, 1'b1);
		frame(8'h80, 8'h80, 8'h74, 8'h80, 8'h74, 6'h1f, 6'h22, 1'b0);
		frame(8'h80, 8'h80, 8'h85, 8'h80, 8'h85, 6'h1e, 6'h22, 1'b0);
		wr(`IDX_WB_LOCK, 8'h08);
		frame(8'h80, 8'h80, 8'h85, 8'h80, 8'h85, 6'h1e, 6'h22, 1'b1);
		rdc(`IDX_WB_STATUS, 8'h9e);
		wr(`IDX_WB_LOCK, 8'hb8);
	endtask

	task automatic filterRange();
		frame(8'h80, 8'h80, 8'h74, 8'h80, 8'h74, 6'h1f, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'he0);
		frame(8'h80, 8'h80, 8'h74, 8'h80, 8'h74, 6'h1f, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'he4);
		frame(8'h80, 8'h80, 8'h74, 8'h80, 8'h74, 6'h20, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'h1c);
		frame(8'h80, 8'h60, 8'h74, 8'h60, 8'h74, 6'h20, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'h3c);
		frame(8'h80, 8'h60, 8'h74, 8'h60, 8'h74, 6'h21, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'hfe);
		frame(8'h05, 8'h80, 8'h74, 8'h80, 8'h74, 6'h21, 6'h22, 1'b0);
		wr(`IDX_WB_FILTER, 8'hfc);
		frame(8'h05, 8'h80, 8'h74, 8'h80, 8'h74, 6'h22, 6'h22, 1'b0);
	endtask

	task automatic centerOnly();
		wr(`IDX_WB_FILTER, 8'hfd);
		frame(8'h80, 8'h80, 8'h80, 8'h80, 8'h8c, 6'h22, 6'h22, 1'b1);
		wr(`IDX_WB_FILTER, 8'hfc);
		frame(8'h80, 8'h80, 8'h80, 8'h80, 8'h8c, 6'h21, 6'h22, 1'b0);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		regTest();
		stepClamp();
		lockHyst();
		filterRange();
		centerOnly();
		conclude();
	end
endmodule // awb_ae_window_stats_ctrl_tb
`default_nettype wire

// *** test/awb_stats_sva.sv ***
// Port-level assertions for the statistics and gain controller.
// Assumes the register header on the include path; bound to every controller instance.
`timescale 1ns/1ns
`default_nettype none
`include "awb_ae_consts.vh"
module awb_stats_sva
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pixel stream
	input wire logic        frameStart,
	input wire logic        lineStart,
	input wire logic        frameEnd,
	input wire logic        pixelValid,
	input wire logic [7:0]  pixY,
	input wire logic [7:0]  pixCb,
	input wire logic [7:0]  pixCr,
	// Gains
	input wire logic [5:0]  redGain,
	input wire logic [5:0]  greenGain,
	input wire logic [5:0]  blueGain,
	input wire logic        gainUpdate,
	input wire logic        wbLocked
);
	logic [7:0] upperLimit_reg;
	logic [7:0] lowerLimit_reg;
	wire        wrDone = psel && penable && pready && pwrite;

	// Limit shadows follow completed writes so the gain bounds need no internal probes
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			upperLimit_reg <= `RST_GAIN_UPPER;
			lowerLimit_reg <= `RST_GAIN_LOWER;
		end
		else if (wrDone && paddr[9:2] == `IDX_GAIN_UPPER)
			upperLimit_reg <= pwdata[7:0];
		else if (wrDone && paddr[9:2] == `IDX_GAIN_LOWER)
			lowerLimit_reg <= pwdata[7:0];
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
	property p_ready_single;
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("ready held too long");
	property p_err_with_ready;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error outside access");
	property p_rdata_idle;
		!(pready && !pwrite) |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read access");
	property p_update_timing;
		frameEnd |-> ##3 gainUpdate ##1 !gainUpdate;
	endproperty
	a_update_timing: assert property (p_update_timing) else $error("gain update late");
	property p_update_cause;
		gainUpdate |-> $past(frameEnd, 3);
	endproperty
	a_update_cause: assert property (p_update_cause) else $error("gain update without frame end");
	property p_gain_stable;
		!gainUpdate |-> $stable(redGain) && $stable(blueGain) && $stable(greenGain);
	endproperty
	a_gain_stable: assert property (p_gain_stable) else $error("gain moved between updates");
	property p_lock_on_update;
		$changed(wbLocked) |-> gainUpdate;
	endproperty
	a_lock_on_update: assert property (p_lock_on_update) else $error("lock moved off update");
	property p_locked_hold;
		gainUpdate && wbLocked && $past(wbLocked) |-> $stable(redGain) && $stable(blueGain);
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("gains moved while locked");
	property p_gain_bounds;
		gainUpdate && lowerLimit_reg <= upperLimit_reg && upperLimit_reg <= 8'h3f
			|-> redGain >= lowerLimit_reg && redGain <= upperLimit_reg
			&& blueGain >= lowerLimit_reg && blueGain <= upperLimit_reg
			&& greenGain >= lowerLimit_reg && greenGain <= upperLimit_reg;
	endproperty
	a_gain_bounds: assert property (p_gain_bounds) else $error("gain outside limits");

	c_lock: cover property ($rose(wbLocked));
	c_unlock: cover property ($fell(wbLocked));
	c_error: cover property (pslverr);
	c_step: cover property (gainUpdate && !wbLocked && $changed(redGain));
endmodule // awb_stats_sva

bind awb_ae_window_stats_ctrl awb_stats_sva checker_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frameStart(frameStart), .lineStart(lineStart), .frameEnd(frameEnd), .pixelValid(pixelValid),
	.pixY(pixY), .pixCb(pixCb), .pixCr(pixCr), .redGain(redGain), .greenGain(greenGain),
	.blueGain(blueGain), .gainUpdate(gainUpdate), .wbLocked(wbLocked));
`default_nettype wire

// *** test/image_sensor_model.sv ***
// Behavioural image sensor: sends a six by three frame on request and takes the gains it is sent.
// Assumes a grid of two-pixel columns and one-line rows, so the centre is line 1, pixels 2 and 3.
`timescale 1ns/1ns
`default_nettype none
module image_sensor_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Frame request and colours inside and outside the centre window
	input  wire logic       go,
	input  wire logic [7:0] lumaIn,
	input  wire logic [7:0] cbIn,
	input  wire logic [7:0] crIn,
	input  wire logic [7:0] cbOut,
	input  wire logic [7:0] crOut,
	output logic            busy,
	// Pixel stream
	output logic            frameStart,
	output logic            lineStart,
	output logic            frameEnd,
	output logic            pixelValid,
	output logic [7:0]      pixY,
	output logic [7:0]      pixCb,
	output logic [7:0]      pixCr,
	// Gains
	input  wire logic       gainUpdate,
	input  wire logic [5:0] redGain,
	input  wire logic [5:0] greenGain,
	input  wire logic [5:0] blueGain,
	output logic [5:0]      sensorRed,
	output logic [5:0]      sensorGreen,
	output logic [5:0]      sensorBlue
);
	// Idle pixel lines flip so a stale value is never mistaken for data
	task automatic idlePixels();
		pixY <= ~pixY;
		pixCb <= ~pixCb;
		pixCr <= ~pixCr;
	endtask

	task automatic sendFrame();
		logic inCenter;
		busy <= 1'b1;
		frameStart <= 1'b1;
		@(posedge clk);
		frameStart <= 1'b0;
		for (int ln = 0; ln < 3; ln++)
		begin
			lineStart <= 1'b1;
			pixelValid <= 1'b0;
			idlePixels();
			@(posedge clk);
			lineStart <= 1'b0;
			for (int px = 0; px < 6; px++)
			begin
				inCenter = (ln == 1) && (px == 2 || px == 3);
				pixelValid <= 1'b1;
				pixY <= lumaIn;
				pixCb <= inCenter ? cbIn : cbOut;
				pixCr <= inCenter ? crIn : crOut;
				@(posedge clk);
			end
		end
		pixelValid <= 1'b0;
		frameEnd <= 1'b1;
		idlePixels();
		@(posedge clk);
		frameEnd <= 1'b0;
		repeat (6) @(posedge clk);
		busy <= 1'b0;
	endtask

	initial
	begin
		{busy, frameStart, lineStart, frameEnd, pixelValid} = 5'h00;
		{pixY, pixCb, pixCr} = 24'h5a5a5a;
		forever
		begin
			@(posedge clk);
			if (go === 1'b1 && rst_n === 1'b1)
				sendFrame();
		end
	end

	always @(posedge clk)
	begin
		if (!rst_n)
			{sensorRed, sensorGreen, sensorBlue} <= 18'h0;
		else if (gainUpdate === 1'b1)
			{sensorRed, sensorGreen, sensorBlue} <= {redGain, greenGain, blueGain};
	end
endmodule // image_sensor_model
`default_nettype wire

// *** verilog/awb_ae_consts.vh ***
// Register map, field positions, reset values and limits of the statistics and gain controller.
// Assumes inclusion by bare name from the design files under verilog/.
`ifndef AWB_AE_CONSTS_VH
`define AWB_AE_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_CORNER_W   8'ha1
`define IDX_SIDE_W     8'ha2
`define IDX_CENTER_W   8'ha3
`define IDX_CORNER_H   8'ha4
`define IDX_SIDE_H     8'ha5
`define IDX_CENTER_H   8'ha6
`define IDX_GAIN_UPPER 8'ha7
`define IDX_GAIN_LOWER 8'ha8
`define IDX_WB_FILTER  8'ha9
`define IDX_WB_LOCK    8'haa
`define IDX_TARGET_CR  8'hf0
`define IDX_TARGET_CB  8'hf1
`define IDX_WB_STATUS  8'hf2
`define IDX_GREEN_SET  8'hf3
`define IDX_STAT_SEL   8'hf4
`define IDX_STAT_Y     8'hf5
`define IDX_STAT_CB    8'hf6
`define IDX_STAT_CR    8'hf7

// Reset values
`define RST_CORNER_W   8'h00
`define RST_SIDE_W     8'h96
`define RST_CENTER_W   8'h96
`define RST_CORNER_H   8'h00
`define RST_SIDE_H     8'h50
`define RST_CENTER_H   8'h0a
`define RST_GAIN_UPPER 8'h3f
`define RST_GAIN_LOWER 8'h14
`define RST_WB_FILTER  8'hff
`define RST_WB_LOCK    8'hb8
`define RST_TARGET     8'h80
`define RST_GREEN      6'h20

// Field positions
`define FLT_SUM_HI   7
`define FLT_SUM_LO   5
`define FLT_CR_HI    4
`define FLT_CR_LO    2
`define FLT_LUM      1
`define FLT_CENTER   0
`define LCK_SPLIT    7
`define LCK_LOCK_HI  6
`define LCK_LOCK_LO  4
`define LCK_UNL_HI   3
`define LCK_UNL_LO   0

// Pixel filter and gain limits
`define GAIN_MAX     8'h3f
`define CHROMA_MID   9'h080
`define LUM_DARK     8'h10
`define LUM_BRIGHT   8'heb
`define ZONE_NONE    4'h9
`define ZONE_CENTER  4'h4
`define NUM_WIN      9

`endif

// *** verilog/awb_ae_window_stats_ctrl.v ***
// Window statistics, white-balance lock loop and sensor gain control with an APB register slave.
// Assumes a pixel stream in YCbCr with frame and line pulses, and a sensor that takes the gains.
`timescale 1ns/1ns
`default_nettype none
`include "awb_ae_consts.vh"
module awb_ae_window_stats_ctrl
(
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Pixel stream
	input  wire        frameStart,
	input  wire        lineStart,
	input  wire        frameEnd,
	input  wire        pixelValid,
	input  wire [7:0]  pixY,
	input  wire [7:0]  pixCb,
	input  wire [7:0]  pixCr,
	// Gains to the image sensor
	output reg  [5:0]  redGain,
	output reg  [5:0]  greenGain,
	output reg  [5:0]  blueGain,
	output reg         gainUpdate,
	output reg         wbLocked
);
	localparam ST_ACC   = 3'b001;
	localparam ST_EVAL  = 3'b010;
	localparam ST_APPLY = 3'b100;

	reg  [7:0]  cornerW_reg, sideW_reg, centerW_reg;
	reg  [7:0]  cornerH_reg, sideH_reg, centerH_reg;
	reg  [7:0]  gainUpper_reg, gainLower_reg;
	reg  [7:0]  wbFilter_reg, wbLock_reg;
	reg  [7:0]  targetCr_reg, targetCb_reg;
	reg  [5:0]  greenSet_reg;
	reg  [3:0]  statSel_reg;
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [7:0]  dY_reg, dCb_reg, dCr_reg;
	reg         pixOk_reg;
	reg  [27:0] wbCr_reg, wbCb_reg;
	reg  [19:0] wbCnt_reg;
	reg  [27:0] crDiff_reg, cbDiff_reg;
	reg         crHigh_reg, cbHigh_reg;
	reg  [19:0] cnt_reg;
	reg  [27:0] sumY  [0:`NUM_WIN-1];
	reg  [27:0] sumCb [0:`NUM_WIN-1];
	reg  [27:0] sumCr [0:`NUM_WIN-1];
	wire [3:0]  zone;
	wire [7:0]  regIdx = paddr[9:2];
	wire        wrEn = psel & penable & pready & pwrite;

	window_locator locator
	(
		.clk          (clk),
		.rst_n        (rst_n),
		.frameStart   (frameStart),
		.lineStart    (lineStart),
		.pixelValid   (pixelValid),
		.cornerWidth  (cornerW_reg),
		.sideWidth    (sideW_reg),
		.centerWidth  (centerW_reg),
		.cornerHeight (cornerH_reg),
		.sideHeight   (sideH_reg),
		.centerHeight (centerH_reg),
		.zone         (zone)
	);

	// Pixel acceptance: chroma offsets around mid scale
	wire [8:0]  crOff = {1'b0, pixCr} - `CHROMA_MID;
	wire [8:0]  cbOff = {1'b0, pixCb} - `CHROMA_MID;
	wire [7:0]  crAbs = crOff[8] ? (~crOff[7:0] + 8'h01) : crOff[7:0];
	wire [7:0]  cbAbs = cbOff[8] ? (~cbOff[7:0] + 8'h01) : cbOff[7:0];
	wire [8:0]  sumAbs = {1'b0, crAbs} + {1'b0, cbAbs};
	wire [2:0]  crSel = wbFilter_reg[`FLT_CR_HI:`FLT_CR_LO];
	wire [2:0]  sumSel = wbFilter_reg[`FLT_SUM_HI:`FLT_SUM_LO];
	// Larger setting widens the accepted white spot
	wire        crOk = {1'b0, crAbs} <= {3'b000, crSel, 3'b111};
	wire        sumOk = sumAbs <= {1'b0, sumSel, 5'b11111};
	wire        lumOk = !wbFilter_reg[`FLT_LUM] || ((pixY >= `LUM_DARK) && (pixY <= `LUM_BRIGHT));
	wire        inZone = zone != `ZONE_NONE;
	wire        wbZone = wbFilter_reg[`FLT_CENTER] ? (zone == `ZONE_CENTER) : inZone;
	wire        accOn = state_reg == ST_ACC;

	// Per-window luminance and colour-difference sums
	genvar w;
	generate
		for (w = 0; w < `NUM_WIN; w = w + 1)
		begin : winAcc
			always @(posedge clk)
			begin
				if (!rst_n || frameStart)
				begin
					sumY[w]  <= 28'h0000000;
					sumCb[w] <= 28'h0000000;
					sumCr[w] <= 28'h0000000;
				end
				else if (accOn && (zone == w))
				begin
					sumY[w]  <= sumY[w] + {20'h00000, dY_reg};
					sumCb[w] <= sumCb[w] + {20'h00000, dCb_reg};
					sumCr[w] <= sumCr[w] + {20'h00000, dCr_reg};
				end
			end
		end
	endgenerate

	// Pixel data delayed to line up with the registered zone
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			dY_reg    <= 8'h00;
			dCb_reg   <= 8'h00;
			dCr_reg   <= 8'h00;
			pixOk_reg <= 1'b0;
		end
		else
		begin
			dY_reg    <= pixY;
			dCb_reg   <= pixCb;
			dCr_reg   <= pixCr;
			pixOk_reg <= crOk && sumOk && lumOk;
		end
	end

	// White-balance sums over accepted pixels of the chosen windows
	always @(posedge clk)
	begin
		if (!rst_n || frameStart)
		begin
			wbCr_reg  <= 28'h0000000;
			wbCb_reg  <= 28'h0000000;
			wbCnt_reg <= 20'h00000;
		end
		else if (accOn && wbZone && pixOk_reg)
		begin
			wbCr_reg  <= wbCr_reg + {20'h00000, dCr_reg};
			wbCb_reg  <= wbCb_reg + {20'h00000, dCb_reg};
			wbCnt_reg <= wbCnt_reg + 20'h00001;
		end
	end

	// Frame sequencing: evaluation only after the frame closes
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_ACC:
				if (frameEnd)
					state_next = ST_EVAL;
			ST_EVAL:
				state_next = ST_APPLY;
			ST_APPLY:
				state_next = ST_ACC;
			default:
				state_next = ST_ACC;
		endcase
	end

	// Means are never divided out: sums are compared against target and ranges scaled by the count
	wire [27:0] crGoal = {20'h00000, targetCr_reg} * {8'h00, wbCnt_reg};
	wire [27:0] cbGoal = {20'h00000, targetCb_reg} * {8'h00, wbCnt_reg};
	wire [3:0]  lockRange = {1'b0, wbLock_reg[`LCK_LOCK_HI:`LCK_LOCK_LO]};
	wire [3:0]  unlockRange = wbLock_reg[`LCK_UNL_HI:`LCK_UNL_LO];
	// Single threshold unless split thresholds are enabled
	wire [3:0]  lockSel = wbLock_reg[`LCK_SPLIT] ? lockRange : unlockRange;
	wire [27:0] lockTh = {24'h000000, lockSel} * {8'h00, cnt_reg};
	wire [27:0] unlockTh = {24'h000000, unlockRange} * {8'h00, cnt_reg};
	wire        nowBal = (crDiff_reg < lockTh) && (cbDiff_reg < lockTh);
	wire        nowOff = (crDiff_reg > unlockTh) || (cbDiff_reg > unlockTh);
	// Clamp limits: lower limit, upper limit and the sensor's own ceiling
	wire [7:0]  hiLim = (gainUpper_reg > `GAIN_MAX) ? `GAIN_MAX : gainUpper_reg;
	wire [7:0]  loLim = (gainLower_reg > hiLim) ? hiLim : gainLower_reg;

	function [5:0] clampGain;
		input [7:0] val;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (val < lo)
				clampGain = lo[5:0];
			else if (val > hi)
				clampGain = hi[5:0];
			else
				clampGain = val[5:0];
		end
	endfunction

	wire [7:0]  redUp = {2'b00, redGain} + 8'h01;
	wire [7:0]  redDn = (redGain == 6'h00) ? 8'h00 : {2'b00, redGain} - 8'h01;
	wire [7:0]  blueUp = {2'b00, blueGain} + 8'h01;
	wire [7:0]  blueDn = (blueGain == 6'h00) ? 8'h00 : {2'b00, blueGain} - 8'h01;

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg  <= ST_ACC;
			crDiff_reg <= 28'h0000000;
			cbDiff_reg <= 28'h0000000;
			crHigh_reg <= 1'b0;
			cbHigh_reg <= 1'b0;
			cnt_reg    <= 20'h00000;
			redGain    <= `RST_GREEN;
			greenGain  <= `RST_GREEN;
			blueGain   <= `RST_GREEN;
			gainUpdate <= 1'b0;
			wbLocked   <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			gainUpdate <= 1'b0;
			if (state_reg == ST_EVAL)
			begin
				// Distance of the frame mean from target, kept in summed units
				crHigh_reg <= wbCr_reg > crGoal;
				cbHigh_reg <= wbCb_reg > cbGoal;
				crDiff_reg <= (wbCr_reg > crGoal) ? wbCr_reg - crGoal : crGoal - wbCr_reg;
				cbDiff_reg <= (wbCb_reg > cbGoal) ? wbCb_reg - cbGoal : cbGoal - wbCb_reg;
				cnt_reg    <= wbCnt_reg;
			end
			if (state_reg == ST_APPLY)
			begin
				gainUpdate <= 1'b1;
				greenGain  <= clampGain({2'b00, greenSet_reg}, loLim, hiLim);
				if (cnt_reg == 20'h00000)
				begin
					// No white pixels: hold the gains inside limits only
					redGain  <= clampGain({2'b00, redGain}, loLim, hiLim);
					blueGain <= clampGain({2'b00, blueGain}, loLim, hiLim);
				end
				else if (!wbLocked || nowOff)
				begin
					// Crossing the unlock range steps at once, losing no frame
					if (!wbLocked && nowBal)
					begin
						wbLocked <= 1'b1;
						redGain  <= clampGain({2'b00, redGain}, loLim, hiLim);
						blueGain <= clampGain({2'b00, blueGain}, loLim, hiLim);
					end
					else
					begin
						// Red follows Cr, blue follows Cb, one step a frame
						wbLocked <= 1'b0;
						redGain  <= clampGain(crHigh_reg ? redDn : redUp, loLim, hiLim);
						blueGain <= clampGain(cbHigh_reg ? blueDn : blueUp, loLim, hiLim);
					end
				end
				else
				begin
					redGain  <= clampGain({2'b00, redGain}, loLim, hiLim);
					blueGain <= clampGain({2'b00, blueGain}, loLim, hiLim);
				end
			end
		end
	end

	// Register writes; horizontal sizes taken as given, scaling is software's job
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			cornerW_reg   <= `RST_CORNER_W;
			sideW_reg     <= `RST_SIDE_W;
			centerW_reg   <= `RST_CENTER_W;
			cornerH_reg   <= `RST_CORNER_H;
			sideH_reg     <= `RST_SIDE_H;
			centerH_reg   <= `RST_CENTER_H;
			gainUpper_reg <= `RST_GAIN_UPPER;
			gainLower_reg <= `RST_GAIN_LOWER;
			wbFilter_reg  <= `RST_WB_FILTER;
			wbLock_reg    <= `RST_WB_LOCK;
			targetCr_reg  <= `RST_TARGET;
			targetCb_reg  <= `RST_TARGET;
			greenSet_reg  <= `RST_GREEN;
			statSel_reg   <= 4'h0;
		end
		else if (wrEn)
		begin
			case (regIdx)
				`IDX_CORNER_W:   cornerW_reg   <= pwdata[7:0];
				`IDX_SIDE_W:     sideW_reg     <= pwdata[7:0];
				`IDX_CENTER_W:   centerW_reg   <= pwdata[7:0];
				`IDX_CORNER_H:   cornerH_reg   <= pwdata[7:0];
				`IDX_SIDE_H:     sideH_reg     <= pwdata[7:0];
				`IDX_CENTER_H:   centerH_reg   <= pwdata[7:0];
				`IDX_GAIN_UPPER: gainUpper_reg <= pwdata[7:0];
				`IDX_GAIN_LOWER: gainLower_reg <= pwdata[7:0];
				`IDX_WB_FILTER:  wbFilter_reg  <= pwdata[7:0];
				`IDX_WB_LOCK:    wbLock_reg    <= pwdata[7:0];
				`IDX_TARGET_CR:  targetCr_reg  <= pwdata[7:0];
				`IDX_TARGET_CB:  targetCb_reg  <= pwdata[7:0];
				`IDX_GREEN_SET:  greenSet_reg  <= pwdata[5:0];
				`IDX_STAT_SEL:   statSel_reg   <= (pwdata[3:0] > 4'h8) ? 4'h8 : pwdata[3:0];
				default:         statSel_reg   <= statSel_reg;
			endcase
		end
	end

	// Read mux; an unknown index answers zero with an error
	reg [7:0] rdByte;
	reg       rdHit;
	always @*
	begin
		rdByte = 8'h00;
		rdHit  = 1'b1;
		case (regIdx)
			`IDX_CORNER_W:   rdByte = cornerW_reg;
			`IDX_SIDE_W:     rdByte = sideW_reg;
			`IDX_CENTER_W:   rdByte = centerW_reg;
			`IDX_CORNER_H:   rdByte = cornerH_reg;
			`IDX_SIDE_H:     rdByte = sideH_reg;
			`IDX_CENTER_H:   rdByte = centerH_reg;
			`IDX_GAIN_UPPER: rdByte = gainUpper_reg;
			`IDX_GAIN_LOWER: rdByte = gainLower_reg;
			`IDX_WB_FILTER:  rdByte = wbFilter_reg;
			`IDX_WB_LOCK:    rdByte = wbLock_reg;
			`IDX_TARGET_CR:  rdByte = targetCr_reg;
			`IDX_TARGET_CB:  rdByte = targetCb_reg;
			`IDX_WB_STATUS:  rdByte = {wbLocked, 1'b0, redGain};
			`IDX_GREEN_SET:  rdByte = {2'b00, greenSet_reg};
			`IDX_STAT_SEL:   rdByte = {4'h0, statSel_reg};
			`IDX_STAT_Y:     rdByte = sumY[statSel_reg][23:16];
			`IDX_STAT_CB:    rdByte = sumCb[statSel_reg][23:16];
			`IDX_STAT_CR:    rdByte = sumCr[statSel_reg][23:16];
			default:         rdHit  = 1'b0;
		endcase
	end

	// Zero wait states: pready rises for the access phase only
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable & ~pready;
			if (psel & ~penable)
			begin
				prdata  <= pwrite ? 32'h00000000 : {24'h000000, rdByte};
				pslverr <= ~rdHit;
			end
			else if (pready)
			begin
				prdata  <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end
endmodule // awb_ae_window_stats_ctrl
`default_nettype wire

// *** verilog/window_locator.v ***
// Pixel position tracking and three-by-three window zone lookup.
// Assumes lineStart and frameStart are one-cycle pulses carrying no pixel.
`timescale 1ns/1ns
`default_nettype none
`include "awb_ae_consts.vh"
module window_locator
(
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Video timing
	input  wire       frameStart,
	input  wire       lineStart,
	input  wire       pixelValid,
	// Window sizes
	input  wire [7:0] cornerWidth,
	input  wire [7:0] sideWidth,
	input  wire [7:0] centerWidth,
	input  wire [7:0] cornerHeight,
	input  wire [7:0] sideHeight,
	input  wire [7:0] centerHeight,
	// Zone of the current pixel, one cycle late
	output reg  [3:0] zone
);
	reg  [11:0] xCnt_reg;
	reg  [11:0] yCnt_reg;
	reg  [1:0]  col;
	reg  [1:0]  row;
	reg         colIn;
	reg         rowIn;
	wire [11:0] xA = {4'h0, cornerWidth};
	wire [11:0] xB = xA + {4'h0, sideWidth};
	wire [11:0] xC = xB + {4'h0, centerWidth};
	wire [11:0] xD = xC + {4'h0, sideWidth};
	wire [11:0] yA = {4'h0, cornerHeight};
	wire [11:0] yB = yA + {4'h0, sideHeight};
	wire [11:0] yC = yB + {4'h0, centerHeight};
	wire [11:0] yD = yC + {4'h0, sideHeight};

	// Grid starts after the corner offset, then side, centre, side
	always @*
	begin
		colIn = (xCnt_reg >= xA) && (xCnt_reg < xD);
		col = (xCnt_reg < xB) ? 2'd0 : ((xCnt_reg < xC) ? 2'd1 : 2'd2);
		rowIn = (yCnt_reg >= yA) && (yCnt_reg < yD);
		row = (yCnt_reg < yB) ? 2'd0 : ((yCnt_reg < yC) ? 2'd1 : 2'd2);
	end

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			xCnt_reg <= 12'h000;
			yCnt_reg <= 12'h000;
			zone     <= `ZONE_NONE;
		end
		else
		begin
			if (frameStart)
			begin
				yCnt_reg <= 12'h000;
				xCnt_reg <= 12'h000;
			end
			else if (lineStart)
			begin
				xCnt_reg <= 12'h000;
				if (xCnt_reg != 12'h000)
					yCnt_reg <= yCnt_reg + 12'h001;
			end
			else if (pixelValid)
				xCnt_reg <= xCnt_reg + 12'h001;
			if (pixelValid && colIn && rowIn)
				zone <= {1'b0, row, 1'b0} + {2'b00, row} + {2'b00, col};
			else
				zone <= `ZONE_NONE;
		end
	end
endmodule // window_locator
`default_nettype wire
